// File: hw/atss_core.sv
// atss_core: alive-toggle watchdog timing and safe-output sequencing.
// assumes inputs synchronous to CLK except ALIVE_IN, which is resynchronised here;
// control bits come from an outside register block as plain levels and pulses.
`timescale 1ns/100ps
`default_nettype none

module atss_core import atss_pkg::*; #(
  parameter int SLOW_CYC = SLOW_DET_CYC,  // slow-detect limit in cycles
  parameter int REN_CYC = REN_WIN_CYC,    // re-enable first-edge window in cycles
  parameter int TB_CYC = TB_TICK_CYC      // cycles per safe-state time base tick
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // alive toggle from the controller
  input wire logic ALIVE_IN,
  // control levels and pulses
  input wire logic MON_EN,
  input wire logic RECOVERY_MODE,
  input wire logic [2:0] REC_SEL,
  input wire logic [2:0] SS2_SEL,
  input wire logic SLEEP_EXIT,
  input wire logic SAFE_REQ,
  input wire logic SAFE_RELEASE,
  // safe outputs, active low means safe state
  output logic SAFE_OUT_PRIMARY,
  output logic SAFE_OUT_SECONDARY,
  // status
  output logic FAIL_IRQ,
  output logic FAULT_FAST,
  output logic FAULT_SLOW,
  output logic [1:0] STATE
);

  // all state of the block
  typedef struct packed {
    atss_state_t st;   // reaction state
    logic s1;          // synchroniser first stage
    logic s2;          // synchroniser second stage
    logic prev;        // last synchronised level
    logic mon;         // previous MON_EN, for rising detection
    logic [15:0] ivl;  // cycles since last edge, saturating
    logic grace;       // waiting for first edge
    logic gsleep;      // grace is the sleep-exit kind
    logic [16:0] pre;  // time base prescaler
    logic [8:0] dly;   // time base tick counter
    logic pri;
    logic sec;
    logic irq;
    logic ffast;
    logic fslow;
  } atss_reg_t;

  atss_reg_t r_q;
  atss_reg_t r_d;

  // recovery delay in ticks
  function automatic logic [8:0] rec_ticks(input logic [2:0] sel);
    unique case (sel)
      SEL_D1: rec_ticks = 9'(REC_D1_US / TB_TICK_US);
      SEL_D2: rec_ticks = 9'(REC_D2_US / TB_TICK_US);
      SEL_D3: rec_ticks = 9'(REC_D3_US / TB_TICK_US);
      SEL_D4: rec_ticks = 9'(REC_D4_US / TB_TICK_US);
      default: rec_ticks = 9'h000;  // zero and unused codes mean no delay
    endcase
  endfunction

  // secondary output delay in ticks
  function automatic logic [8:0] ss2_ticks(input logic [2:0] sel);
    unique case (sel)
      SEL_D1: ss2_ticks = 9'(SS2_D1_US / TB_TICK_US);
      SEL_D2: ss2_ticks = 9'(SS2_D2_US / TB_TICK_US);
      SEL_D3: ss2_ticks = 9'(SS2_D3_US / TB_TICK_US);
      SEL_D4: ss2_ticks = 9'(SS2_D4_US / TB_TICK_US);
      default: ss2_ticks = 9'h000;
    endcase
  endfunction

  // decoded events, combinational
  logic edge_det;
  logic fast_evt;
  logic slow_evt;
  logic gexp_evt;
  logic fail_evt;
  logic valid_edge;
  logic tick;

  // edge, threshold and grace decoding
  always_comb begin
    edge_det = r_q.s2 ^ r_q.prev;
    tick = (r_q.pre == 17'(TB_CYC - 1));
    fast_evt = MON_EN && edge_det && !r_q.grace && (r_q.ivl < 16'(FAST_DET_CYC));
    slow_evt = MON_EN && !r_q.grace && (r_q.ivl == 16'(SLOW_CYC));
    // no first edge inside the grace window is a failure too
    gexp_evt = MON_EN && r_q.grace && (r_q.gsleep ?
               (tick && (r_q.dly == SLEEP_TO_TICKS - 9'h001)) :
               (r_q.ivl == 16'(REN_CYC)));
    fail_evt = fast_evt || slow_evt || gexp_evt;
    valid_edge = MON_EN && edge_det && !fast_evt;
  end

  // next-state logic
  always_comb begin
    r_d = r_q;
    r_d.s1 = ALIVE_IN;
    r_d.s2 = r_q.s1;
    r_d.prev = r_q.s2;
    r_d.mon = MON_EN;
    r_d.irq = 1'b0;
    r_d.pre = tick ? 17'h00000 : r_q.pre + 17'h00001;
    if (tick && r_q.dly != 9'h1FF) begin
      r_d.dly = r_q.dly + 9'h001;
    end
    // interval counter restarts on each recognised edge
    if (edge_det) begin
      r_d.ivl = 16'h0000;
      r_d.grace = 1'b0;
    end else if (r_q.ivl != 16'hFFFF) begin
      r_d.ivl = r_q.ivl + 16'h0001;
    end
    // re-enable opens a short first-edge window
    if (MON_EN && !r_q.mon) begin
      r_d.ivl = 16'h0000;
      r_d.grace = 1'b1;
      r_d.gsleep = 1'b0;
    end
    // sleep exit opens the long window, timed on the time base
    if (SLEEP_EXIT) begin
      r_d.grace = 1'b1;
      r_d.gsleep = 1'b1;
      r_d.pre = 17'h00000;
      r_d.dly = 9'h000;
    end
    unique case (r_q.st)
      // both outputs low until released
      ST_SAFE: begin
        if (SAFE_RELEASE) begin
          r_d.st = ST_RUN;
          r_d.pri = 1'b1;
          r_d.sec = 1'b1;
          r_d.ffast = 1'b0;
          r_d.fslow = 1'b0;
          r_d.ivl = 16'h0000;  // restart monitoring like a re-enable
          r_d.grace = 1'b1;
          r_d.gsleep = 1'b0;
        end
      end
      // monitoring with outputs high
      ST_RUN: begin
        if (SAFE_REQ) begin
          r_d.st = ST_SS2W;
          r_d.pri = 1'b0;
          r_d.pre = 17'h00000;
          r_d.dly = 9'h000;
        end else if (fail_evt) begin
          r_d.ffast = r_q.ffast || fast_evt;
          r_d.fslow = r_q.fslow || slow_evt || gexp_evt;
          r_d.pre = 17'h00000;
          r_d.dly = 9'h000;
          if (RECOVERY_MODE && rec_ticks(REC_SEL) != 9'h000) begin
            r_d.st = ST_RECOV;
            r_d.irq = 1'b1;
          end else begin
            r_d.st = ST_SS2W;
            r_d.pri = 1'b0;
          end
        end
      end
      // recovery delay: valid toggling resumes or the outputs trip
      ST_RECOV: begin
        r_d.ffast = r_q.ffast || fast_evt;
        r_d.fslow = r_q.fslow || slow_evt;
        if (SAFE_REQ || (tick && r_q.dly == rec_ticks(REC_SEL) - 9'h001)) begin
          r_d.st = ST_SS2W;
          r_d.pri = 1'b0;
          r_d.pre = 17'h00000;
          r_d.dly = 9'h000;
        end else if (valid_edge) begin
          r_d.st = ST_RUN;
        end
      end
      // primary low, secondary waits for its delay
      ST_SS2W: begin
        if (ss2_ticks(SS2_SEL) == 9'h000 ||
            (tick && r_q.dly == ss2_ticks(SS2_SEL) - 9'h001)) begin
          r_d.st = ST_SAFE;
          r_d.sec = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flip-flops
  assign SAFE_OUT_PRIMARY = r_q.pri;
  assign SAFE_OUT_SECONDARY = r_q.sec;
  assign FAIL_IRQ = r_q.irq;
  assign FAULT_FAST = r_q.ffast;
  assign FAULT_SLOW = r_q.fslow;
  assign STATE = r_q.st;

  // a short interval in run state raises the fast fault next cycle
  property p_fast_det;
    @(posedge CLK) disable iff (!RSTN)
      (r_q.st == ST_RUN && !SAFE_REQ && fast_evt) |=> FAULT_FAST;
  endproperty
  a_fast_det: assert property (p_fast_det) else $error("fast interval not flagged");

  // reaching the slow limit without an edge raises the slow fault
  property p_slow_det;
    @(posedge CLK) disable iff (!RSTN)
      (r_q.st == ST_RUN && !SAFE_REQ && MON_EN && !r_q.grace && !edge_det &&
       r_q.ivl == 16'(SLOW_CYC)) |=> FAULT_SLOW;
  endproperty
  a_slow_det: assert property (p_slow_det) else $error("slow interval not flagged");

  // recovery mode: interrupt pulse and primary output kept high
  sequence s_rec_start;
    r_q.st == ST_RUN && !SAFE_REQ && fail_evt && RECOVERY_MODE && REC_SEL != SEL_D0 &&
      REC_SEL <= SEL_D4;
  endsequence
  property p_rec_irq;
    @(posedge CLK) disable iff (!RSTN)
      s_rec_start |=> FAIL_IRQ && SAFE_OUT_PRIMARY ##1 !FAIL_IRQ;
  endproperty
  a_rec_irq: assert property (p_rec_irq) else $error("recovery start wrong");

  // valid edge during recovery returns to run with outputs high
  property p_rec_resume;
    @(posedge CLK) disable iff (!RSTN)
      (r_q.st == ST_RECOV && valid_edge && !SAFE_REQ && !tick) |=>
        STATE == ST_RUN && SAFE_OUT_PRIMARY && SAFE_OUT_SECONDARY;
  endproperty
  a_rec_resume: assert property (p_rec_resume) else $error("no resume on toggle");

  // immediate mode trips the primary output on the next edge
  property p_immediate;
    @(posedge CLK) disable iff (!RSTN)
      (r_q.st == ST_RUN && fail_evt && !RECOVERY_MODE) |=> !SAFE_OUT_PRIMARY;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate trip missing");

  // secondary never falls before the primary
  property p_order;
    @(posedge CLK) disable iff (!RSTN)
      $fell(SAFE_OUT_SECONDARY) |-> !SAFE_OUT_PRIMARY && $past(!SAFE_OUT_PRIMARY);
  endproperty
  a_order: assert property (p_order) else $error("secondary fell first");

  // zero secondary delay: secondary follows within a few cycles
  property p_ss2_zero;
    @(posedge CLK) disable iff (!RSTN)
      ($fell(SAFE_OUT_PRIMARY) && SS2_SEL == SEL_D0) |-> ##[1:2] !SAFE_OUT_SECONDARY;
  endproperty
  a_ss2_zero: assert property (p_ss2_zero) else $error("secondary late");

  // a safe request in run drops the primary at once
  property p_react;
    @(posedge CLK) disable iff (!RSTN)
      (r_q.st == ST_RUN && SAFE_REQ) |=> !SAFE_OUT_PRIMARY && STATE == ST_SS2W;
  endproperty
  a_react: assert property (p_react) else $error("primary reaction late");

  // enabling monitoring opens the first-edge window
  property p_reenable;
    @(posedge CLK) disable iff (!RSTN)
      (MON_EN && !r_q.mon && !edge_det) |=> r_q.grace && r_q.ivl == 16'h0000;
  endproperty
  a_reenable: assert property (p_reenable) else $error("grace window not opened");

endmodule

`default_nettype wire

// File: hw/atss_pkg.sv
// atss_pkg: constants for the alive-toggle safe-state timing core.
// assumes a single 100 MHz clock; detection times and the tick are turned into cycle counts here, the sleep exit timeout into ticks.
package atss_pkg;

  // clock period
  localparam int CLK_PERIOD_NS = 10;

  // fast-detect threshold, inside the 5.2 .. 11.1 us window with 10 % margin
  localparam int FAST_DET_NS = 8000;
  localparam int FAST_DET_CYC = (FAST_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slow-detect threshold, inside the 50.1 .. 99.9 us window with 10 % margin
  localparam int SLOW_DET_NS = 75000;
  localparam int SLOW_DET_CYC = SLOW_DET_NS / CLK_PERIOD_NS;
  // first edge expected after monitoring is re-enabled, inside 50.1 .. 110 us
  localparam int REN_WIN_NS = 100000;
  localparam int REN_WIN_CYC = REN_WIN_NS / CLK_PERIOD_NS;

  // safe-state time base tick of 0.5 ms
  localparam int TB_TICK_NS = 500000;
  localparam int TB_TICK_CYC = TB_TICK_NS / CLK_PERIOD_NS;
  localparam int TB_TICK_US = TB_TICK_NS / 1000;
  // sleep exit reactivation timeout, 10 ms typical
  localparam int SLEEP_TO_US = 10000;
  localparam logic [8:0] SLEEP_TO_TICKS = 9'(SLEEP_TO_US / TB_TICK_US);

  // recovery delay selections in us: 0, 1.0, 2.5, 5.0, 10 ms
  localparam int REC_D1_US = 1000;
  localparam int REC_D2_US = 2500;
  localparam int REC_D3_US = 5000;
  localparam int REC_D4_US = 10000;
  // secondary output delay selections in us: 0, 10, 50, 100, 250 ms
  localparam int SS2_D1_US = 10000;
  localparam int SS2_D2_US = 50000;
  localparam int SS2_D3_US = 100000;
  localparam int SS2_D4_US = 250000;

  // selection codes for both delays
  localparam logic [2:0] SEL_D0 = 3'h0;
  localparam logic [2:0] SEL_D1 = 3'h1;
  localparam logic [2:0] SEL_D2 = 3'h2;
  localparam logic [2:0] SEL_D3 = 3'h3;
  localparam logic [2:0] SEL_D4 = 3'h4;

  // reaction states
  typedef enum logic [1:0] {
    ST_SAFE = 2'b00,  // both outputs low
    ST_RUN = 2'b01,   // both outputs high, monitoring
    ST_RECOV = 2'b10, // failure seen, recovery delay running
    ST_SS2W = 2'b11   // primary low, secondary delay running
  } atss_state_t;

endpackage

// File: testbench/atss_alive_src.sv
// atss_alive_src: controller side model that toggles the alive line.
// assumes the bench sets the half period in cycles; zero freezes the line at its level.
`timescale 1ns/100ps
`default_nettype none
module atss_alive_src (
  // clock
  input wire logic clk,
  // half period in cycles, zero holds the present level (stuck line)
  input wire logic [15:0] half,
  // alive line towards the core
  output logic alive
);
  logic [15:0] cnt_q; // cycles since the last toggle, saturating

  // start saturated so a restarted toggle comes at once
  initial begin
    alive = 1'b0;
    cnt_q = 16'hFFFF;
  end

  // toggle on the falling edge so the core always samples a settled level
  always @(negedge clk) begin
    if (half != 16'h0 && cnt_q >= half) begin
      alive <= ~alive;
      cnt_q <= 16'h1;
    end else if (cnt_q != 16'hFFFF) begin // hold count at the top when stopped
      cnt_q <= cnt_q + 16'h1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_alive_toggle_safe_state_timing.sv
// tb_alive_toggle_safe_state_timing: self-checking bench for the safe-state timing core.
// assumes the alive model in atss_alive_src; long counts are shortened by parameters.
`timescale 1ns/100ps
`default_nettype none
module tb_alive_toggle_safe_state_timing import atss_pkg::*;;
  localparam int SLOW = 1000; // slow limit, kept above the fixed fast limit of 800
  localparam int REN = 1200;  // first-edge window after re-arm
  localparam int TBC = 10;    // cycles per time base tick, shortened for run time
  // stimulus and observed signals
  logic clk, rstn, alive, mon, rmode, slp, sreq, srel;
  logic prim, sec, irq, ffast, fslow;
  logic [2:0] rsel, s2sel;
  logic [1:0] state;
  logic [15:0] half;
  int errors, num_checks, n, i;
  // expected delays in us per selection code
  int rec_us [5] = '{0, REC_D1_US, REC_D2_US, REC_D3_US, REC_D4_US};
  int s2_us [5] = '{0, SS2_D1_US, SS2_D2_US, SS2_D3_US, SS2_D4_US};

  atss_core #(.SLOW_CYC(SLOW), .REN_CYC(REN), .TB_CYC(TBC)) DUT (
    .CLK(clk), .RSTN(rstn), .ALIVE_IN(alive), .MON_EN(mon), .RECOVERY_MODE(rmode),
    .REC_SEL(rsel), .SS2_SEL(s2sel), .SLEEP_EXIT(slp), .SAFE_REQ(sreq),
    .SAFE_RELEASE(srel), .SAFE_OUT_PRIMARY(prim), .SAFE_OUT_SECONDARY(sec),
    .FAIL_IRQ(irq), .FAULT_FAST(ffast), .FAULT_SLOW(fslow), .STATE(state));
  atss_alive_src CTRL (.clk(clk), .half(half), .alive(alive));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // us to cycles through the shortened tick
  function automatic int cyc(input int us);
    return us / TB_TICK_US * TBC;
  endfunction

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  // bounded wait for an output level: 0 primary, 1 secondary, 2 interrupt
  task automatic wait_lvl(input int sel, input logic lvl, input int bound, output int cnt);
    logic v;
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
      v = (sel == 0) ? prim : (sel == 1) ? sec : irq;
    end while (v !== lvl && cnt < bound);
    if (v !== lvl) begin
      errors++;
      complete_run();
    end
  endtask

  // freeze the line just after an edge so the slow count starts from a known point
  task automatic stop_alive();
    logic a;
    int k;
    a = alive;
    k = 0;
    while (alive === a && k < 2000) begin
      @(negedge clk);
      k++;
    end
    // a line that never toggles here is a hang, not a pass
    if (alive === a) begin
      errors++;
      complete_run();
    end
    half <= 16'h0;
  endtask

  // release from safe state; first edge lands well inside the valid interval
  task automatic rearm();
    half <= 16'h0;
    srel = 1'b1;
    @(negedge clk);
    srel = 1'b0;
    chk(16'({prim, sec, state}), 16'hD);
    repeat (880) @(negedge clk);
    half <= 16'(850 + $urandom % 100);
  endtask

  // secondary follows primary after the selected delay, then state is safe
  task automatic trip2(input int d2);
    wait_lvl(1, 1'b0, d2 + 50, n);
    chk_rng(n, d2, d2 + 3);
    chk(16'(state), 16'h0);
  endtask

  initial begin
    rstn = 1'b0;
    mon = 1'b1;
    rmode = 1'b0;
    rsel = 3'h0;
    s2sel = 3'h0;
    slp = 1'b0;
    sreq = 1'b0;
    srel = 1'b0;
    half = 16'h0;
    errors = 0;
    num_checks = 0;
    void'($urandom(92109));
    repeat (5) @(negedge clk);
    chk(16'({prim, sec, irq, state}), 16'h0);
    rstn = 1'b1;
    // immediate mode: stuck line over every secondary delay code
    for (i = 0; i < 5; i++) begin
      s2sel = 3'(i);
      rearm();
      repeat (3000) @(negedge clk);
      chk(16'(state), 16'h1);
      stop_alive();
      wait_lvl(0, 1'b0, SLOW + 50, n);
      chk_rng(n, SLOW - 5, SLOW + 10);
      chk(16'({ffast, fslow}), 16'h1);
      trip2(cyc(s2_us[i]));
    end
    // a single short interval trips the fast check
    // recovery mode with the zero delay code must react like immediate mode
    rmode = 1'b1;
    s2sel = SEL_D0;
    rearm();
    repeat (2000) @(negedge clk);
    half <= 16'h190;
    wait_lvl(0, 1'b0, 1000, n);
    chk(16'({ffast, fslow}), 16'h2);
    trip2(0);
    // recovery mode: interrupt, then trip after each non-zero delay code
    for (i = 1; i < 5; i++) begin
      rsel = 3'(i);
      rearm();
      repeat (2000) @(negedge clk);
      stop_alive();
      wait_lvl(2, 1'b1, SLOW + 50, n);
      chk(16'(state), 16'h2);
      wait_lvl(0, 1'b0, cyc(rec_us[i]) + 50, n);
      chk_rng(n, cyc(rec_us[i]), cyc(rec_us[i]) + 3);
      trip2(0);
    end
    // recovery: toggling resumes inside the delay, outputs stay high
    rearm();
    repeat (2000) @(negedge clk);
    stop_alive();
    wait_lvl(2, 1'b1, SLOW + 50, n);
    half <= 16'h384;
    repeat (3000) @(negedge clk);
    chk(16'({prim, sec, state}), 16'hD);
    // monitoring off: a stuck line is ignored, a direct request still trips
    rmode = 1'b0;
    mon = 1'b0;
    half <= 16'h0;
    repeat (3000) @(negedge clk);
    chk(16'({prim, sec, state}), 16'hD);
    sreq = 1'b1;
    @(negedge clk);
    sreq = 1'b0;
    chk(16'(prim), 16'h0);
    trip2(0);
    mon = 1'b1;
    // sleep exit opens the long first-edge window, timed on the time base
    rearm();
    repeat (2000) @(negedge clk);
    stop_alive();
    // let the last edge clear the synchroniser, else it closes the long window at once
    repeat (5) @(negedge clk);
    slp = 1'b1;
    @(negedge clk);
    slp = 1'b0;
    wait_lvl(0, 1'b0, SLOW, n);
    chk_rng(n, int'(SLEEP_TO_TICKS) * TBC - 3, int'(SLEEP_TO_TICKS) * TBC + 5);
    chk(16'({ffast, fslow}), 16'h1);
    trip2(0);
    // reset in mid-run forces the safe state at once
    rearm();
    repeat (1500) @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk(16'({prim, sec, irq, state}), 16'h0);
    // release again: the block must come back safe and be re-armable
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'({prim, sec, irq, state}), 16'h0);
    rearm();
    complete_run();
  end
endmodule
`default_nettype wire
